// >>> hdl/synth_cfg_defines.vh
`ifndef SYNTH_CFG_DEFINES_VH
`define SYNTH_CFG_DEFINES_VH

// serial word layout
`define WORD_W 24
`define CTRL_MSB 2
`define CTRL_LSB 0
`define NUM_REGS 8

// register addresses (control bits)
`define ADDR_INT_DIV 3'h0
`define ADDR_MODULUS 3'h1
`define ADDR_FRAC 3'h2
`define ADDR_DITHER 3'h3
`define ADDR_CHARGE_PUMP 3'h4
`define ADDR_LO_PATH 3'h5
`define ADDR_VCO 3'h6
`define ADDR_EXT_VCO 3'h7

// integer divide control fields
`define DIV_KIND_BIT 10
`define INT_RATIO_MSB 9
`define INT_RATIO_LSB 3

// reset values
`define RST_INT_DIV 24'h0001c0
`define RST_MODULUS 24'h003001
`define RST_FRAC 24'h001802
`define RST_OTHER 24'h000000

// modulus and fraction fields
`define MOD_MSB 13
`define MOD_LSB 3
`define FRAC_MSB 13
`define FRAC_LSB 3

`endif

// >>> hdl/pin_sync.v
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter W = 3
) (
  // clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire clk_en_i,
  // async level in, synchronised level out
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else if (clk_en_i) begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule // pin_sync
`default_nettype wire

// >>> hdl/synth_serial_config_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "synth_cfg_defines.vh"

// Function
// [R1] all configuration arrives over three serial pins: clock, data, load enable
// [R2] eight writable configuration registers, 24 bits each
// [R3] host first writes registers 7 down to 0 after power-up
// [R4] afterwards any register may be rewritten in any order
// [R5] registers 0..7: int, modulus, frac, dither, pump, lo, vco, ext vco
// [R6] control bits 000 route word to integer divide control
// [R7] integer divide control resets to 0x0001c0
// [R8] divider kind bit selects fractional or integer feedback divide
// [R9] integer mode: oscillator rate is 2 x detector rate x whole ratio
// [R10] host keeps whole ratio 21..123 in integer mode
// [R11] host keeps whole ratio 24..119 in fractional mode
// [R12] control bits 001 load modulus register, reset 0x003001
// [R13] control bits 010 load fractional register, reset 0x001802
// [R14] host keeps denominator 1..2047 and numerator below it
// [R15] words shift msb first, commit on load enable rising edge
// [R16] host writes zeros into reserved bits
module synth_serial_config_regs (
  // clock, reset, enable
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire clk_en_i,
  // serial programming pins
  input wire ser_clk_i,
  input wire ser_data_i,
  input wire ser_load_i,
  // register contents
  output reg [`WORD_W-1:0] integer_divide_control_o,
  output reg [`WORD_W-1:0] modulus_control_o,
  output reg [`WORD_W-1:0] fractional_control_o,
  output reg [`WORD_W-1:0] dither_control_o,
  output reg [`WORD_W-1:0] charge_pump_control_o,
  output reg [`WORD_W-1:0] lo_path_control_o,
  output reg [`WORD_W-1:0] vco_control_o,
  output reg [`WORD_W-1:0] ext_vco_control_o,
  // decoded divider settings
  output reg divider_kind_select_o,
  output reg [6:0] whole_divide_ratio_o,
  output reg [10:0] denominator_value_o,
  output reg [10:0] numerator_value_o,
  // status
  output reg all_written_o,
  output reg write_strobe_o,
  output reg [2:0] write_addr_o
);
  wire [2:0] pins_sync;
  reg ser_clk_d_ff;
  reg ser_load_d_ff;
  reg [`WORD_W-1:0] shift_ff;
  reg [`NUM_REGS-1:0] written_ff;
  wire clk_rise;
  wire load_rise;
  wire [2:0] addr;

  pin_sync #(.W(3)) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .clk_en_i(clk_en_i),
    .async_i({ser_load_i, ser_data_i, ser_clk_i}),
    .sync_o(pins_sync)
  ); // [R1]

  assign clk_rise = pins_sync[0] & ~ser_clk_d_ff;
  assign load_rise = pins_sync[2] & ~ser_load_d_ff;
  assign addr = shift_ff[`CTRL_MSB:`CTRL_LSB];

  // shift path; data held stable by host around the serial clock edge
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      ser_clk_d_ff <= 1'b0;
      ser_load_d_ff <= 1'b0;
      shift_ff <= {`WORD_W{1'b0}};
    end else if (clk_en_i) begin
      ser_clk_d_ff <= pins_sync[0];
      ser_load_d_ff <= pins_sync[2];
      if (clk_rise) begin
        shift_ff <= {shift_ff[`WORD_W-2:0], pins_sync[1]}; // [R15]
      end
    end
  end

  // one-hot write enable per register; no ordering enforced [R4]
  reg [`NUM_REGS-1:0] reg_we;
  always @* begin
    reg_we = {`NUM_REGS{1'b0}};
    if (load_rise) begin // [R15]
      case (addr) // [R5]
        `ADDR_INT_DIV: reg_we = 8'h01; // [R6]
        `ADDR_MODULUS: reg_we = 8'h02; // [R12]
        `ADDR_FRAC: reg_we = 8'h04; // [R13]
        `ADDR_DITHER: reg_we = 8'h08;
        `ADDR_CHARGE_PUMP: reg_we = 8'h10;
        `ADDR_LO_PATH: reg_we = 8'h20;
        `ADDR_VCO: reg_we = 8'h40;
        `ADDR_EXT_VCO: reg_we = 8'h80;
        default: reg_we = {`NUM_REGS{1'b0}};
      endcase
    end
  end

  // register 0: integer divide control
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      integer_divide_control_o <= `RST_INT_DIV; // [R7]
    end else if (clk_en_i && reg_we[0]) begin
      integer_divide_control_o <= shift_ff; // [R6]
    end
  end

  // register 1: modulus control
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      modulus_control_o <= `RST_MODULUS; // [R12]
    end else if (clk_en_i && reg_we[1]) begin
      modulus_control_o <= shift_ff; // [R12]
    end
  end

  // register 2: fractional control
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      fractional_control_o <= `RST_FRAC; // [R13]
    end else if (clk_en_i && reg_we[2]) begin
      fractional_control_o <= shift_ff; // [R13]
    end
  end

  // register 3: dither control
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      dither_control_o <= `RST_OTHER;
    end else if (clk_en_i && reg_we[3]) begin
      dither_control_o <= shift_ff; // [R5]
    end
  end

  // register 4: charge pump, detector and reference
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      charge_pump_control_o <= `RST_OTHER;
    end else if (clk_en_i && reg_we[4]) begin
      charge_pump_control_o <= shift_ff; // [R5]
    end
  end

  // register 5: lo path and modulator
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      lo_path_control_o <= `RST_OTHER;
    end else if (clk_en_i && reg_we[5]) begin
      lo_path_control_o <= shift_ff; // [R5]
    end
  end

  // register 6: oscillator control
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      vco_control_o <= `RST_OTHER;
    end else if (clk_en_i && reg_we[6]) begin
      vco_control_o <= shift_ff; // [R5]
    end
  end

  // register 7: external oscillator enable
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      ext_vco_control_o <= `RST_OTHER;
    end else if (clk_en_i && reg_we[7]) begin
      ext_vco_control_o <= shift_ff; // [R5]
    end
  end

  // status: written map, strobe and last address
  reg [`NUM_REGS-1:0] nxt_written;
  always @* begin
    nxt_written = written_ff | reg_we; // [R2]
  end

  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      written_ff <= {`NUM_REGS{1'b0}};
      all_written_o <= 1'b0;
      write_strobe_o <= 1'b0;
      write_addr_o <= 3'h0;
    end else if (clk_en_i) begin
      written_ff <= nxt_written;
      // status hint only; early rewrites are never refused
      all_written_o <= &written_ff;
      write_strobe_o <= load_rise;
      if (load_rise) begin
        write_addr_o <= addr;
      end
    end
  end

  // reset images of the decoded fields, cut from the reset words
  localparam [`WORD_W-1:0] rst_int_div_word = `RST_INT_DIV;
  localparam [`WORD_W-1:0] rst_modulus_word = `RST_MODULUS;
  localparam [`WORD_W-1:0] rst_frac_word = `RST_FRAC;

  // decoded fields lag the registers by one cycle
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      divider_kind_select_o <= rst_int_div_word[`DIV_KIND_BIT];
      whole_divide_ratio_o <= rst_int_div_word[`INT_RATIO_MSB:`INT_RATIO_LSB];
      denominator_value_o <= rst_modulus_word[`MOD_MSB:`MOD_LSB];
      numerator_value_o <= rst_frac_word[`FRAC_MSB:`FRAC_LSB];
    end else if (clk_en_i) begin
      divider_kind_select_o <= integer_divide_control_o[`DIV_KIND_BIT]; // [R8]
      // in integer mode the consumer ignores the numerator [R9]
      whole_divide_ratio_o <= integer_divide_control_o[`INT_RATIO_MSB:`INT_RATIO_LSB];
      denominator_value_o <= modulus_control_o[`MOD_MSB:`MOD_LSB];
      numerator_value_o <= fractional_control_o[`FRAC_MSB:`FRAC_LSB];
    end
  end
endmodule // synth_serial_config_regs
`default_nettype wire

// >>> verif/synth_cfg_checker.sv
`timescale 1ns/100ps
`default_nettype none
module synth_cfg_checker (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ser_load_i,
  input wire logic [23:0] integer_divide_control_o,
  input wire logic divider_kind_select_o,
  input wire logic [6:0] whole_divide_ratio_o,
  input wire logic write_strobe_o,
  input wire logic [2:0] write_addr_o
);
  wire [23:0] r0 = integer_divide_control_o;
  wire wr0 = write_strobe_o && write_addr_o == 3'h0;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_rst; disable iff (1'b0) !rst_b_i |=> r0 == 24'h0001c0; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_dk; disable iff (1'b0) !rst_b_i |=> !divider_kind_select_o; endproperty
  a_dk: assert property (p_dk) else $error("kind reset");
  property p_kind; wr0 |=> divider_kind_select_o == r0[10]; endproperty
  a_kind: assert property (p_kind) else $error("kind");
  property p_ratio; wr0 |=> whole_divide_ratio_o == r0[9:3]; endproperty
  a_ratio: assert property (p_ratio) else $error("ratio");
  property p_route; $changed(r0) |-> wr0; endproperty
  a_route: assert property (p_route) else $error("route");
  property p_addr; $changed(write_addr_o) |-> write_strobe_o; endproperty
  a_addr: assert property (p_addr) else $error("addr");
  property p_pulse; write_strobe_o |=> !write_strobe_o; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe");
  property p_load; $rose(ser_load_i) |-> ##[2:6] write_strobe_o; endproperty
  a_load: assert property (p_load) else $error("commit");
endmodule // synth_cfg_checker
bind synth_serial_config_regs synth_cfg_checker chk (.*);
`default_nettype wire

// >>> verif/serial_host.sv
`timescale 1ns/100ps
`default_nettype none
module serial_host (
  input wire logic ref_clk_i,
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic ser_load_o
);
  initial {ser_clk_o, ser_data_o, ser_load_o} = 3'h0;
  // msb first, clock parked low outside frames
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      ser_data_o = w[i];
      repeat (4) @(negedge ref_clk_i);
      ser_clk_o = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      ser_clk_o = 1'b0;
    end
    ser_data_o = ~w[0]; // stale bit must not look valid
    repeat (4) @(negedge ref_clk_i);
    ser_load_o = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    ser_load_o = 1'b0;
  endtask
endmodule // serial_host
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  wire clk_en_i = 1'b1;
  wire ser_clk_i, ser_data_i, ser_load_i, divider_kind_select_o, all_written_o, write_strobe_o;
  wire [23:0] integer_divide_control_o, modulus_control_o, fractional_control_o, dither_control_o;
  wire [23:0] charge_pump_control_o, lo_path_control_o, vco_control_o, ext_vco_control_o;
  wire [10:0] denominator_value_o, numerator_value_o;
  wire [6:0] whole_divide_ratio_o;
  wire [2:0] write_addr_o;
  int n_errors = 0;
  int checks_done = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  serial_host host (.ref_clk_i, .ser_clk_o(ser_clk_i), .ser_data_o(ser_data_i),
    .ser_load_o(ser_load_i));
  synth_serial_config_regs dut (.*);
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, s, e);
    end
  endtask
  // reserved bits sent as zero
  task automatic xfer(input logic [2:0] a, input logic [20:0] p);
    host.send({p, a});
    repeat (2) @(negedge ref_clk_i);
    chk(write_addr_o, a);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    chk(modulus_control_o, 24'h003001);
    chk(fractional_control_o, 24'h001802);
    chk(integer_divide_control_o, 24'h0001c0);
    chk({divider_kind_select_o, whole_divide_ratio_o}, {1'b0, 7'd56});
    chk({denominator_value_o, numerator_value_o}, {11'h600, 11'h300});
    for (int a = 7; a >= 0; a--) xfer(3'(a), a ? 21'(40 - 3 * a) : 21'h0000fb);
    chk(all_written_o, 1'b1);
    chk(integer_divide_control_o, 24'h0007d8);
    chk({divider_kind_select_o, whole_divide_ratio_o}, {1'b1, 7'd123});
    chk(dither_control_o, 24'h0000fb);
    chk(charge_pump_control_o, 24'h0000e4);
    chk(vco_control_o, 24'h0000b6);
    chk(ext_vco_control_o, 24'h00009f);
    chk({denominator_value_o, numerator_value_o}, {11'd37, 11'd34});
    xfer(3'h0, 21'h000018);
    chk(lo_path_control_o, 24'h0000cd);
    chk(integer_divide_control_o, 24'h0000c0);
    chk({divider_kind_select_o, whole_divide_ratio_o}, {1'b0, 7'd24});
    final_report();
  end
endmodule // testbench
`default_nettype wire
